// ### design/acs_pkg.sv
// Package with constants and carrier types for the converter sequencer
package acs_pkg;
    localparam logic [2:0] ACS_PS_RESET = 3'h0;
    localparam logic [6:0] ACS_DIV_RESET = 7'h00;
    localparam logic [4:0] ACS_NORMAL_CYCLES = 5'h0D;
    localparam logic [4:0] ACS_FIRST_CYCLES = 5'h19;
    localparam logic [4:0] ACS_AUTO_CYCLES = 5'h0E;
    localparam logic [4:0] ACS_NORMAL_SAMPLE = 5'h01;
    localparam logic [4:0] ACS_FIRST_SAMPLE = 5'h0E;
    localparam logic [4:0] ACS_AUTO_SAMPLE = 5'h02;
    localparam logic [4:0] ACS_ONE = 5'h01;
    localparam logic [1:0] ACS_TRIG_SYNC = 2'h3;
    localparam logic [3:0] ACS_CH_RESET = 4'h0;
    localparam logic [2:0] ACS_REF_RESET = 3'h0;
    localparam logic [9:0] ACS_RESULT_RESET = 10'h000;

    typedef struct packed {
        logic [3:0] channel_select;
        logic [2:0] reference_select;
    } acs_sel_t;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_WAIT = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;
endpackage

// ### design/acs_prescaler.sv
// Prescaler producing a one-cycle converter clock rising-edge tick
`timescale 1ns/1ps
module acs_prescaler
    import acs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic hold,
    input wire logic [2:0] prescale_select,
    output logic tick
);
    logic [6:0] div_r;
    logic [6:0] mask;

    // Ratio 2..128: select 0 and 1 both divide by two
    always_comb begin
        mask = 7'h01;
        if (prescale_select > 3'h1) begin
            mask = 7'((8'h01 << prescale_select) - 8'h01);
        end
    end

    // Held in reset while hold is high
    always_ff @(posedge sys_clk) begin
        if (!rstn || hold) begin
            div_r <= ACS_DIV_RESET;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    assign tick = !hold && ((div_r & mask) == mask);
endmodule // acs_prescaler

// ### design/acs_sequencer.sv
// Conversion sequencer around a 10-bit successive approximation converter
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic converter_enable,
    input wire logic auto_trigger_enable,
    input wire logic free_running,
    input wire logic [2:0] prescale_select,
    input wire logic start_write,
    input wire logic done_flag_clear,
    input wire logic done_irq_enable,
    input wire logic trigger_in,
    input wire logic select_write,
    input wire acs_sel_t select_wdata,
    input wire logic cpu_halted,
    input wire logic sleep_noise_or_idle,
    input wire logic result_low_read,
    input wire logic result_high_read,
    input wire logic [9:0] sar_data,
    output logic conversion_start,
    output logic conversion_done_flag,
    output logic done_irq_request,
    output logic sample_hold,
    output logic converter_clk_tick,
    output acs_sel_t active_select,
    output acs_sel_t buffered_select,
    output logic [7:0] result_low_byte,
    output logic [1:0] result_high_byte,
    output logic busy
);
    acs_state_t state_r;
    acs_state_t state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] len_r;
    logic [4:0] samp_r;
    logic first_r;
    logic start_r;
    logic flag_r;
    logic lock_r;
    logic trig_q1_r;
    logic trig_q2_r;
    logic trig_q3_r;
    logic sleep_arm_r;
    logic tick;
    logic trig_event;
    logic pre_hold;
    logic finish;
    logic begin_conv;
    logic sleep_go;
    logic auto_r;
    logic lock_res_r;

    //////////////////////////////////////////////////////////////////////////
    // Prescaler and trigger synchronisation

    // Two CPU cycles of trigger sync, the third stage drives edge detect
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            trig_q1_r <= 1'b0;
            trig_q2_r <= 1'b0;
            trig_q3_r <= 1'b0;
        end else begin
            trig_q1_r <= trigger_in;
            trig_q2_r <= trig_q1_r;
            trig_q3_r <= trig_q2_r;
        end
    end

    // Rising edge only accepted when idle, so edges mid-conversion are dropped
    assign trig_event = converter_enable && auto_trigger_enable && !free_running && trig_q2_r && !trig_q3_r
        && (state_r == ACS_IDLE) && !start_r;
    // Clearing the divider on the accepted trigger fixes the trigger to start delay;
    // the cost is that the converter clock phase is lost at every trigger
    assign pre_hold = !converter_enable || trig_event;

    acs_prescaler u_pre (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .hold(pre_hold),
        .prescale_select(prescale_select),
        .tick(tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // Conversion state machine

    // Completion is the tick that closes the last converter clock of a conversion
    assign finish = (state_r == ACS_CONV) && tick && (cnt_r == len_r);
    // Sleep start only when idle, single mode and completion interrupt enabled
    assign sleep_go = converter_enable && sleep_noise_or_idle && cpu_halted && done_irq_enable
        && !auto_trigger_enable && (state_r == ACS_IDLE) && !start_r && !sleep_arm_r;
    // Conversion begins on the first converter clock edge after a start request
    assign begin_conv = (state_r == ACS_WAIT) && tick;

    // Next state; disabling the converter aborts any conversion at once
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACS_IDLE: begin
                if (converter_enable && (start_write || trig_event || sleep_go)) begin
                    state_nxt = ACS_WAIT;
                end
            end
            ACS_WAIT: begin
                if (tick) begin
                    state_nxt = ACS_CONV;
                end
            end
            ACS_CONV: begin
                if (finish) begin
                    state_nxt = (free_running && start_r) ? ACS_CONV : ACS_IDLE;
                end
            end
            default: state_nxt = ACS_IDLE;
        endcase
        if (!converter_enable) begin
            state_nxt = ACS_IDLE;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= ACS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Cycle counter and per-conversion length; count 1 is the first clock
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r <= 5'h00;
            len_r <= ACS_NORMAL_CYCLES;
            samp_r <= ACS_NORMAL_SAMPLE;
        end else if (begin_conv || (finish && state_nxt == ACS_CONV)) begin
            cnt_r <= ACS_ONE;
            if (first_r) begin
                len_r <= ACS_FIRST_CYCLES;
                samp_r <= ACS_FIRST_SAMPLE;
            end else if (auto_r) begin
                len_r <= ACS_AUTO_CYCLES;
                samp_r <= ACS_AUTO_SAMPLE;
            end else begin
                len_r <= ACS_NORMAL_CYCLES;
                samp_r <= ACS_NORMAL_SAMPLE;
            end
        end else if (state_r == ACS_CONV && tick) begin
            cnt_r <= cnt_r + ACS_ONE;
        end
    end

    // Marks a trigger-started conversion so it gets the auto length and sample point
    // Cleared at the start tick, so a free running restart falls back to normal length
    always_ff @(posedge sys_clk) begin
        if (!rstn || !converter_enable) begin
            auto_r <= 1'b0;
        end else if (trig_event) begin
            auto_r <= 1'b1;
        end else if (begin_conv) begin
            auto_r <= 1'b0;
        end
    end

    // First conversion marker rearms whenever the converter is disabled
    always_ff @(posedge sys_clk) begin
        if (!rstn || !converter_enable) begin
            first_r <= 1'b1;
        end else if (begin_conv) begin
            first_r <= 1'b0;
        end
    end

    // Start bit: set by write or any start source, cleared at single completion
    always_ff @(posedge sys_clk) begin
        if (!rstn || !converter_enable) begin
            start_r <= 1'b0;
        end else if (start_write || (state_r == ACS_IDLE && (trig_event || sleep_go))) begin
            start_r <= 1'b1;
        end else if (finish && !free_running) begin
            start_r <= 1'b0;
        end
    end

    // One sleep-started conversion per sleep period
    // The arm clears on wake, so the next sleep command may start another
    always_ff @(posedge sys_clk) begin
        if (!rstn || !cpu_halted) begin
            sleep_arm_r <= 1'b0;
        end else if (sleep_go) begin
            sleep_arm_r <= 1'b1;
        end
    end

    // Done flag; set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else if (finish) begin
            flag_r <= 1'b1;
        end else if (done_flag_clear) begin
            flag_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Channel and reference selection buffering

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            buffered_select <= '{channel_select: ACS_CH_RESET, reference_select: ACS_REF_RESET};
        end else if (select_write) begin
            buffered_select <= select_wdata;
        end
    end

    // Lock from conversion start; unlock in last converter clock
    // A free running restart relocks at once, so a late reselect hits the result after next
    always_ff @(posedge sys_clk) begin
        if (!rstn || !converter_enable) begin
            lock_r <= 1'b0;
        end else if (begin_conv) begin
            lock_r <= 1'b1;
        end else if (state_r == ACS_CONV && tick && (cnt_r + ACS_ONE == len_r)) begin
            lock_r <= 1'b0;
        end else if (finish && state_nxt == ACS_CONV) begin
            lock_r <= 1'b1;
        end
    end

    // Selection takes effect only while enabled and unlocked
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            active_select <= '{channel_select: ACS_CH_RESET, reference_select: ACS_REF_RESET};
        end else if (converter_enable && !lock_r && !begin_conv) begin
            active_select <= buffered_select;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Results and outputs

    // Low byte read blocks updates until the high byte is read
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lock_res_r <= 1'b0;
        end else if (result_high_read) begin
            lock_res_r <= 1'b0;
        end else if (result_low_read) begin
            lock_res_r <= 1'b1;
        end
    end

    // A discarded result still sets the done flag; only the data registers hold
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result_low_byte <= ACS_RESULT_RESET[7:0];
            result_high_byte <= ACS_RESULT_RESET[9:8];
        end else if (finish && !lock_res_r) begin
            result_low_byte <= sar_data[7:0];
            result_high_byte <= sar_data[9:8];
        end
    end

    // Registered status and strobes; irq request pulses even if CPU woke early
    // One cycle of lag on each status and strobe output is traded for glitch-free pins
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            conversion_start <= 1'b0;
            conversion_done_flag <= 1'b0;
            done_irq_request <= 1'b0;
            sample_hold <= 1'b0;
            converter_clk_tick <= 1'b0;
            busy <= 1'b0;
        end else begin
            conversion_start <= start_r;
            conversion_done_flag <= flag_r;
            done_irq_request <= finish && done_irq_enable;
            sample_hold <= (state_r == ACS_CONV) && tick && (cnt_r == samp_r);
            converter_clk_tick <= tick;
            busy <= (state_r != ACS_IDLE);
        end
    end

endmodule // acs_sequencer

// ### verification/acs_sequencer_checker.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_checker
    import acs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic converter_enable,
    input wire logic auto_trigger_enable,
    input wire logic free_running,
    input wire logic [2:0] prescale_select,
    input wire logic done_irq_enable,
    input wire logic result_low_read,
    input wire logic result_high_read,
    input wire logic conversion_start,
    input wire logic conversion_done_flag,
    input wire logic done_irq_request,
    input wire logic sample_hold,
    input wire logic converter_clk_tick,
    input wire logic [7:0] result_low_byte,
    input wire logic [1:0] result_high_byte,
    input wire logic busy
);
    logic lock_r;
    // Open from a low byte read until the high byte read
    always_ff @(posedge sys_clk) begin
        if (!rstn) lock_r <= 1'b0;
        else if (result_high_read) lock_r <= 1'b0;
        else if (result_low_read) lock_r <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Three cycles low covers the registered lag of the tick
    property p_hold_off; !converter_enable [*3] |-> !converter_clk_tick; endproperty
    a_hold_off: assert property (p_hold_off) else $error("tick while disabled");
    property p_div_two; converter_clk_tick && prescale_select == 3'h0 && !auto_trigger_enable |=> !converter_clk_tick; endproperty
    a_div_two: assert property (p_div_two) else $error("tick spacing short");
    property p_clear_done; $rose(conversion_done_flag) && !free_running |-> !conversion_start; endproperty
    a_clear_done: assert property (p_clear_done) else $error("start bit kept at done");
    property p_fall_done; $fell(conversion_start) && converter_enable && $past(converter_enable) |-> conversion_done_flag; endproperty
    a_fall_done: assert property (p_fall_done) else $error("start bit fell early");
    property p_free_keep; free_running && auto_trigger_enable && converter_enable && conversion_start ##1 free_running && auto_trigger_enable && converter_enable |-> conversion_start; endproperty
    a_free_keep: assert property (p_free_keep) else $error("free run start bit dropped");
    property p_sample_in; sample_hold |-> busy || $past(busy); endproperty
    a_sample_in: assert property (p_sample_in) else $error("sample outside conversion");
    property p_irq_done; $rose(conversion_done_flag) && $past(done_irq_enable, 2) |-> $past(done_irq_request); endproperty
    a_irq_done: assert property (p_irq_done) else $error("no done request");
    property p_lock; lock_r && $past(lock_r) |-> $stable({result_high_byte, result_low_byte}); endproperty
    a_lock: assert property (p_lock) else $error("result changed while locked");
endmodule // acs_sequencer_checker
bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_i (.sys_clk, .rstn, .converter_enable,
    .auto_trigger_enable, .free_running, .prescale_select, .done_irq_enable, .result_low_read,
    .result_high_read, .conversion_start, .conversion_done_flag, .done_irq_request, .sample_hold,
    .converter_clk_tick, .result_low_byte, .result_high_byte, .busy);

// ### verification/tb_acs_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_acs_sequencer;
    import acs_pkg::*;
    typedef struct packed {
        logic [4:0] ticks;
        logic [9:0] res;
    } acs_note_t;
    logic sys_clk, rstn, converter_enable, auto_trigger_enable, free_running, start_write, done_flag_clear;
    logic done_irq_enable, trigger_in, select_write, cpu_halted, sleep_noise_or_idle, result_low_read;
    logic result_high_read, conversion_start, conversion_done_flag, done_irq_request, sample_hold;
    logic converter_clk_tick, busy, flag_q, trig_q, start_q;
    logic [2:0] prescale_select;
    logic [9:0] sar_data, last_res, tick_cnt, samp_cnt;
    logic [7:0] result_low_byte;
    logic [1:0] result_high_byte;
    acs_sel_t select_wdata, active_select, buffered_select, sel, osel;
    acs_note_t notes[$];
    acs_note_t note;
    integer seed = 32'h0BEB;
    int n_fail, n_compared, n_irq, k;
    acs_sequencer acs_sequencer_i (.sys_clk, .rstn, .converter_enable, .auto_trigger_enable, .free_running,
        .prescale_select, .start_write, .done_flag_clear, .done_irq_enable, .trigger_in, .select_write,
        .select_wdata, .cpu_halted, .sleep_noise_or_idle, .result_low_read, .result_high_read, .sar_data,
        .conversion_start, .conversion_done_flag, .done_irq_request, .sample_hold, .converter_clk_tick,
        .active_select, .buffered_select, .result_low_byte, .result_high_byte, .busy);
    // 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task do_start;
        start_write <= 1'b1;
        @(posedge sys_clk);
        start_write <= 1'b0;
    endtask
    // Clear waits out the output lag so the next rise is seen
    task clear_done;
        done_flag_clear <= 1'b1;
        @(posedge sys_clk);
        done_flag_clear <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task write_sel;
        sel = 7'($random(seed));
        select_wdata <= sel;
        select_write <= 1'b1;
        @(posedge sys_clk);
        select_write <= 1'b0;
    endtask
    // Notes the expected ticks (zero skips) and result; hold keeps the old result
    task arm(input logic [4:0] t, input bit hold);
        logic [9:0] r;
        r = 10'($random(seed));
        sar_data <= r;
        if (!hold) last_res = r;
        notes.push_back('{t, last_res});
    endtask
    // Bounded wait, a hang ends the run
    task wait_done;
        int i;
        for (i = 0; i < 3000 && conversion_done_flag !== 1'b1; i++) @(posedge sys_clk);
        if (i == 3000) begin
            n_fail++;
            end_of_test;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Watcher: ticks since the last start or trigger, oldest note at each done rise
    always @(posedge sys_clk) begin
        flag_q <= conversion_done_flag;
        trig_q <= trigger_in;
        start_q <= start_write;
        if (done_irq_request === 1'b1) n_irq++;
        if (sample_hold === 1'b1) samp_cnt <= tick_cnt;
        tick_cnt <= (converter_clk_tick === 1'b1) ? tick_cnt + 10'h001 : tick_cnt;
        // Start is taken one edge late so a tick from the idle cycle of the write is dropped
        if (start_q || (trigger_in && !trig_q)) tick_cnt <= 10'h000;
        if (conversion_done_flag === 1'b1 && flag_q === 1'b0) begin
            note = notes.pop_front();
            if (note.ticks != 5'h00) check(tick_cnt, {5'h00, note.ticks});
            if (note.ticks != 5'h00)
                check(samp_cnt, (note.ticks == 5'h1A) ? 10'(ACS_FIRST_SAMPLE) : 10'(ACS_NORMAL_SAMPLE));
            check({result_high_byte, result_low_byte}, note.res);
        end
    end
    initial begin
        {rstn, converter_enable, auto_trigger_enable, free_running, start_write, done_flag_clear} = '0;
        {done_irq_enable, trigger_in, select_write, cpu_halted, sleep_noise_or_idle} = '0;
        {result_low_read, result_high_read} = '0;
        {prescale_select, sar_data, select_wdata, last_res} = '0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        converter_enable <= 1'b1;
        prescale_select <= 3'h6;
        write_sel;
        repeat (3) @(posedge sys_clk);
        check({3'h0, active_select}, {3'h0, sel});
        check({3'h0, buffered_select}, {3'h0, sel});
        arm(5'h1A, 0);
        do_start;
        wait_done;
        clear_done;
        // Reselect mid conversion at prescale select 0 to 3; one tick of start plus the length
        for (k = 0; k < 4; k++) begin
            prescale_select <= k[2:0];
            osel = sel;
            arm(5'h0E, 0);
            do_start;
            repeat (12) @(posedge sys_clk);
            // Results are exact digital copies, so none is discarded after a reference change
            write_sel;
            repeat (2) @(posedge sys_clk);
            check({3'h0, active_select}, {3'h0, osel});
            check({9'h000, conversion_start}, 10'h001);
            wait_done;
            repeat (2) @(posedge sys_clk);
            check({3'h0, active_select}, {3'h0, sel});
            clear_done;
        end
        // Low byte read blocks the next result, then the high byte unlocks
        for (k = 1; k >= 0; k--) begin
            result_low_read <= (k == 1);
            result_high_read <= (k == 0);
            @(posedge sys_clk);
            {result_low_read, result_high_read} <= 2'b00;
            arm(5'h0E, k == 1);
            do_start;
            wait_done;
            clear_done;
        end
        // Free running: three results, start bit stays up
        {auto_trigger_enable, free_running} <= 2'b11;
        arm(5'h00, 0);
        notes.push_back('{5'h00, last_res});
        notes.push_back('{5'h00, last_res});
        do_start;
        repeat (3) begin
            wait_done;
            clear_done;
        end
        check({9'h000, conversion_start}, 10'h001);
        {converter_enable, auto_trigger_enable, free_running} <= 3'b000;
        repeat (6) @(posedge sys_clk);
        converter_enable <= 1'b1;
        arm(5'h1A, 0);
        do_start;
        wait_done;
        clear_done;
        // Trigger edge starts; a second edge held high through completion is ignored
        auto_trigger_enable <= 1'b1;
        arm(5'h00, 0);
        trigger_in <= 1'b1;
        repeat (8) @(posedge sys_clk);
        trigger_in <= 1'b0;
        repeat (8) @(posedge sys_clk);
        // Reselect more than one converter clock after the trigger, inside the conversion
        write_sel;
        trigger_in <= 1'b1;
        wait_done;
        clear_done;
        check({3'h0, active_select}, {3'h0, sel});
        repeat (200) @(posedge sys_clk);
        trigger_in <= 1'b0;
        check(10'(notes.size()), 10'h000);
        check({9'h000, conversion_done_flag}, 10'h000);
        // Short halt in noise mode still starts and still requests at completion
        {auto_trigger_enable, done_irq_enable, sleep_noise_or_idle, cpu_halted} <= 4'b0111;
        arm(5'h00, 0);
        repeat (4) @(posedge sys_clk);
        {sleep_noise_or_idle, cpu_halted} <= 2'b00;
        wait_done;
        repeat (3) @(posedge sys_clk);
        check(10'(n_irq), 10'h001);
        end_of_test;
    end
endmodule // tb_acs_sequencer
